// *** ees_pkg.sv ***
// Shared constants for the two-wire EEPROM slave
package ees_pkg;
  localparam int         MEM_AW      = 18;
  localparam int         PAGE_AW     = 8;
  localparam int         PAGE_BYTES  = 256;
  localparam logic [3:0] DEV_MAIN    = 4'ha;
  localparam logic [3:0] DEV_ID      = 4'hb;
  localparam logic [7:0] LOCK_ADDR_H = 8'h04;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [3:0] BIT_REL     = 4'h9;
  localparam int         CLK_MHZ     = 250;
  localparam int         T_WR_MAX_MS = 5;
  localparam int         T_WR_CYC    = T_WR_MAX_MS * 1000 * CLK_MHZ;
  localparam int         SYNC_N      = 4;
  localparam int         SYNC_SCL    = 0;
  localparam int         SYNC_SDA    = 1;
  localparam int         SYNC_WP     = 2;
  localparam int         SYNC_CS     = 3;
  localparam logic [3:0] SYNC_RST    = 4'h3;
endpackage : ees_pkg

// *** ees_pins_if.sv ***
// Filtered pin levels passed from the synchroniser to the slave core
interface ees_pins_if;
  logic scl;
  logic sda;
  logic wp;
  logic cs;
  modport src (output scl, output sda, output wp, output cs);
  modport dst (input scl, input sda, input wp, input cs);
endinterface : ees_pins_if

// *** ees_sync.sv ***
// Three-stage pin synchroniser with agreement filter
module ees_sync (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Raw pins
  input  wire logic [ees_pkg::SYNC_N-1:0] raw,
  // Filtered levels
  ees_pins_if.src                         pins
);
  typedef struct packed {
    logic [ees_pkg::SYNC_N-1:0] s1;
    logic [ees_pkg::SYNC_N-1:0] s2;
    logic [ees_pkg::SYNC_N-1:0] s3;
    logic [ees_pkg::SYNC_N-1:0] flt;
  } ees_sync_t;

  ees_sync_t st_ff;
  ees_sync_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < ees_pkg::SYNC_N; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.flt[i] = st_ff.s2[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= {4{ees_pkg::SYNC_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins.scl = st_ff.flt[ees_pkg::SYNC_SCL];
  assign pins.sda = st_ff.flt[ees_pkg::SYNC_SDA];
  assign pins.wp  = st_ff.flt[ees_pkg::SYNC_WP];
  assign pins.cs  = st_ff.flt[ees_pkg::SYNC_CS];
endmodule : ees_sync

// *** ees_slave.sv ***
// Two-wire EEPROM slave core with page buffer and timed write cycle
module ees_slave #(
  parameter int       WR_CYCLES  = ees_pkg::T_WR_CYC,
  parameter bit       ID_PAGE_EN = 1'b1
) (
  // Clock and power-on reset
  input  wire logic clk,
  input  wire logic rst,
  // Bus pins
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  // Straps
  input  wire logic wp,
  input  wire logic chip_select_addr_bit,
  // Status
  output logic      standby,
  output logic      busy
);
  localparam int TMR_W = $clog2(WR_CYCLES + 1);
  localparam int AW    = ees_pkg::MEM_AW;
  localparam int PW    = ees_pkg::PAGE_AW;

  typedef enum logic [3:0] {
    ST_STANDBY, ST_DEV, ST_ADH, ST_ADL, ST_WR, ST_RD, ST_RACK, ST_WAIT, ST_PROG
  } ees_state_t;

  typedef struct packed {
    ees_state_t                     state;
    logic                           scl_prev;
    logic                           sda_prev;
    logic [3:0]                     bit_cnt;
    logic [7:0]                     shreg;
    logic                           id_sel;
    logic                           lock_req;
    logic                           pend;
    logic                           mack;
    logic [AW-1:0]                  addr;
    logic [ees_pkg::PAGE_BYTES-1:0] mask;
    logic [PW:0]                    prog_idx;
    logic [TMR_W-1:0]               timer;
    logic                           drv_lvl;
    logic                           sda_oe_n;
    logic                           standby;
    logic                           busy;
  } ees_core_t;

  localparam ees_core_t RST_ST = '{state: ST_STANDBY, scl_prev: 1'b1, sda_prev: 1'b1,
                                   sda_oe_n: 1'b1, standby: 1'b1, default: '0};

  ees_pins_if pins ();

  ees_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .raw  ({chip_select_addr_bit, wp, sda_in, scl}),
    .pins (pins)
  );

  ees_core_t  st_ff;
  ees_core_t  nxt_st;
  logic [7:0] mem [2**AW];
  logic [7:0] id_mem [ees_pkg::PAGE_BYTES];
  logic [7:0] pbuf [ees_pkg::PAGE_BYTES];
  logic       id_lock_nv = 1'b0;
  logic [7:0] rd_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       writable;
  logic       commit;
  logic       mem_we;
  logic       id_we;
  logic       lock_set;
  logic       buf_we;
  logic [PW-1:0] pidx;

  assign scl_rise  = pins.scl & ~st_ff.scl_prev;
  assign scl_fall  = ~pins.scl & st_ff.scl_prev;
  assign start_det = pins.scl & st_ff.scl_prev & st_ff.sda_prev & ~pins.sda;
  assign stop_det  = pins.scl & st_ff.scl_prev & ~st_ff.sda_prev & pins.sda;
  assign writable  = ~pins.wp & ~(st_ff.id_sel & id_lock_nv);
  assign pidx      = st_ff.prog_idx[PW-1:0];
  assign commit    = (st_ff.state == ST_PROG) & ~st_ff.prog_idx[PW] & st_ff.mask[pidx]
                     & writable;
  assign mem_we    = commit & ~st_ff.id_sel;
  assign id_we     = commit & st_ff.id_sel;
  assign lock_set  = (st_ff.state == ST_PROG) & st_ff.lock_req & writable;
  assign rd_byte   = st_ff.id_sel ? id_mem[st_ff.addr[PW-1:0]] : mem[st_ff.addr];

  always_comb begin
    nxt_st          = st_ff;
    buf_we          = 1'b0;
    nxt_st.scl_prev = pins.scl;
    nxt_st.sda_prev = pins.sda;
    if (st_ff.state == ST_PROG) begin
      if (!st_ff.prog_idx[PW]) begin
        nxt_st.prog_idx = st_ff.prog_idx + 1'b1;
      end
      if (st_ff.timer == TMR_W'(WR_CYCLES - 1)) begin
        nxt_st.state   = ST_STANDBY;
        nxt_st.standby = 1'b1;
        nxt_st.busy    = 1'b0;
      end else begin
        nxt_st.timer = st_ff.timer + 1'b1;
      end
    end else if (start_det) begin
      nxt_st.state    = ST_DEV;
      nxt_st.bit_cnt  = '0;
      nxt_st.sda_oe_n = 1'b1;
      nxt_st.standby  = 1'b0;
      nxt_st.pend     = 1'b0;
      nxt_st.lock_req = 1'b0;
    end else if (stop_det) begin
      nxt_st.sda_oe_n = 1'b1;
      if (st_ff.pend) begin
        nxt_st.state    = ST_PROG;
        nxt_st.pend     = 1'b0;
        nxt_st.timer    = '0;
        nxt_st.prog_idx = '0;
        nxt_st.busy     = 1'b1;
      end else begin
        nxt_st.state   = ST_STANDBY;
        nxt_st.standby = 1'b1;
      end
    end else if (st_ff.state inside {ST_DEV, ST_ADH, ST_ADL, ST_WR}) begin
      if (scl_rise && st_ff.bit_cnt < ees_pkg::BIT_ACK) begin
        nxt_st.shreg   = {st_ff.shreg[6:0], pins.sda};
        nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
      end else if (scl_fall && st_ff.bit_cnt == ees_pkg::BIT_ACK) begin
        nxt_st.bit_cnt  = ees_pkg::BIT_REL;
        nxt_st.sda_oe_n = 1'b0;
        unique case (st_ff.state)
          ST_DEV: begin
            if ((st_ff.shreg[7:4] == ees_pkg::DEV_MAIN ||
                 (ID_PAGE_EN && st_ff.shreg[7:4] == ees_pkg::DEV_ID)) &&
                st_ff.shreg[3] == pins.cs) begin
              nxt_st.id_sel = (st_ff.shreg[7:4] == ees_pkg::DEV_ID);
              if (st_ff.shreg[7:4] == ees_pkg::DEV_MAIN) begin
                nxt_st.addr[AW-1:AW-2] = st_ff.shreg[2:1];
              end
              nxt_st.state = st_ff.shreg[0] ? ST_RD : ST_ADH;
            end else begin
              nxt_st.sda_oe_n = 1'b1;
              nxt_st.state    = ST_WAIT;
            end
          end
          ST_ADH: begin
            nxt_st.addr[15:8] = st_ff.shreg;
            nxt_st.lock_req   = st_ff.id_sel & (st_ff.shreg == ees_pkg::LOCK_ADDR_H);
            nxt_st.state      = ST_ADL;
          end
          ST_ADL: begin
            nxt_st.addr[7:0] = st_ff.shreg;
            nxt_st.mask      = '0;
            nxt_st.state     = ST_WR;
          end
          ST_WR: begin
            if (writable) begin
              if (!st_ff.lock_req) begin
                buf_we                        = 1'b1;
                nxt_st.mask[st_ff.addr[7:0]] = 1'b1;
              end
              nxt_st.pend      = 1'b1;
              nxt_st.addr[7:0] = st_ff.addr[7:0] + 1'b1;
            end else begin
              nxt_st.sda_oe_n = 1'b1;
              nxt_st.state    = ST_WAIT;
            end
          end
        endcase
      end else if (scl_fall && st_ff.bit_cnt == ees_pkg::BIT_REL) begin
        nxt_st.bit_cnt  = '0;
        nxt_st.sda_oe_n = 1'b1;
      end
    end else if (st_ff.state == ST_RD && scl_fall) begin
      if (st_ff.bit_cnt == ees_pkg::BIT_REL) begin
        nxt_st.sda_oe_n = rd_byte[7];
        nxt_st.shreg    = {rd_byte[6:0], 1'b0};
        nxt_st.bit_cnt  = 4'h1;
      end else if (st_ff.bit_cnt < ees_pkg::BIT_ACK) begin
        nxt_st.sda_oe_n = st_ff.shreg[7];
        nxt_st.shreg    = {st_ff.shreg[6:0], 1'b0};
        nxt_st.bit_cnt  = st_ff.bit_cnt + 1'b1;
      end else begin
        nxt_st.sda_oe_n = 1'b1;
        nxt_st.state    = ST_RACK;
        nxt_st.mack     = 1'b0;
        nxt_st.addr     = st_ff.addr + 1'b1;
      end
    end else if (st_ff.state == ST_RACK) begin
      if (scl_rise) begin
        nxt_st.mack = ~pins.sda;
      end else if (scl_fall) begin
        if (st_ff.mack) begin
          nxt_st.state    = ST_RD;
          nxt_st.sda_oe_n = rd_byte[7];
          nxt_st.shreg    = {rd_byte[6:0], 1'b0};
          nxt_st.bit_cnt  = 4'h1;
        end else begin
          nxt_st.state = ST_WAIT;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (buf_we) begin
      pbuf[st_ff.addr[PW-1:0]] <= st_ff.shreg;
    end
    if (mem_we) begin
      mem[{st_ff.addr[AW-1:PW], pidx}] <= pbuf[pidx];
    end
    if (id_we) begin
      id_mem[pidx] <= pbuf[pidx];
    end
    if (lock_set) begin
      id_lock_nv <= 1'b1;
    end
  end

  assign sda_out  = st_ff.drv_lvl;
  assign sda_oe_n = st_ff.sda_oe_n;
  assign standby  = st_ff.standby;
  assign busy     = st_ff.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence dev_byte_done;
    scl_fall && st_ff.state == ST_DEV && st_ff.bit_cnt == ees_pkg::BIT_ACK;
  endsequence

  sequence prog_begin;
    stop_det && st_ff.pend && st_ff.state != ST_PROG;
  endsequence

  a_reset_quiet: assert property ($fell(rst) |-> st_ff.sda_oe_n && st_ff.standby)
    else $error("not released and idle after reset");
  a_dev_match: assert property (dev_byte_done ##0 (st_ff.shreg[7:5] != 3'h5 ||
                                st_ff.shreg[3] != pins.cs) |=> st_ff.sda_oe_n)
    else $error("acked a foreign slave byte");
  a_ack_ninth: assert property ($fell(st_ff.sda_oe_n) && st_ff.state != ST_RD
                                |-> st_ff.bit_cnt == ees_pkg::BIT_REL)
    else $error("ack driven outside ninth clock");
  a_prog_silent: assert property (st_ff.state == ST_PROG |-> st_ff.sda_oe_n && st_ff.busy)
    else $error("bus driven during programming");
  a_prog_start: assert property (prog_begin |=> st_ff.state == ST_PROG ##1 st_ff.timer == 1)
    else $error("stop with pending write did not start cycle");
  a_stop_idle: assert property (stop_det && !st_ff.pend && st_ff.state != ST_PROG
                                |=> st_ff.standby && !st_ff.busy)
    else $error("stop without write did not give standby");
  a_timer_bound: assert property (st_ff.state == ST_PROG
                                  |-> st_ff.timer < TMR_W'(WR_CYCLES))
    else $error("write cycle longer than allowed");
  a_cycle_end: assert property (st_ff.state == ST_PROG && st_ff.timer == TMR_W'(WR_CYCLES - 1)
                                |=> st_ff.state == ST_STANDBY && !st_ff.busy)
    else $error("write cycle did not end on time");
  a_wp_guard: assert property (mem_we || id_we || lock_set |-> !pins.wp)
    else $error("store changed while protected");
  a_lock_guard: assert property (id_we |-> !id_lock_nv)
    else $error("locked page written");
  a_page_wrap: assert property (st_ff.state == ST_WR && $past(st_ff.state) == ST_WR
                                |-> st_ff.addr[AW-1:PW] == $past(st_ff.addr[AW-1:PW]))
    else $error("page write left its page");
endmodule : ees_slave

// *** ees_master_model.sv ***
// Behavioural two-wire bus master that drives the EEPROM slave pins
module ees_master_model #(
  parameter int HALF = 125
) (
  // Clock
  input  wire logic clk,
  // Bus
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released lines float to the pull-up level
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // Each phase of 125 clocks keeps the bus clock at or below 1 MHz
  task automatic half_wait();
    repeat (HALF) @(negedge clk);
  endtask : half_wait

  // Data changes only with the bus clock low, held through the high phase
  task automatic clk_bit(input logic b, output logic s);
    sda_drv = b;
    half_wait();
    scl = 1'b1;
    half_wait();
    s   = sda;
    scl = 1'b0;
    repeat (4) @(negedge clk);
  endtask : clk_bit

  task automatic bus_start();
    sda_drv = 1'b1;
    half_wait();
    scl = 1'b1;
    half_wait();
    sda_drv = 1'b0;
    half_wait();
    scl = 1'b0;
    repeat (4) @(negedge clk);
  endtask : bus_start

  task automatic bus_stop();
    sda_drv = 1'b0;
    half_wait();
    scl = 1'b1;
    half_wait();
    sda_drv = 1'b1;
    half_wait();
  endtask : bus_stop

  // Whole bytes, most significant bit first, then the acknowledge clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(last, s);
  endtask : recv_byte
endmodule : ees_master_model

// *** i2c_eeprom_slave_overview_bench.sv ***
// Self-checking bench for the two-wire EEPROM slave
module i2c_eeprom_slave_overview_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Long enough that a Start sent just after Stop falls inside the cycle
  localparam int WR = 600;

  logic        clk, rst, scl, sda_drv, sda, sda_out, sda_oe_n, wp, cs, standby, busy, ack;
  int          n_errors, checked, busy_len;
  logic [31:0] rnd;
  logic [17:0] a;
  logic [7:0]  d [3];

  // Open-drain wire with pull-up
  assign sda = sda_drv & (sda_oe_n | sda_out);

  ees_slave #(.WR_CYCLES(WR), .ID_PAGE_EN(1'b1)) dut (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wp(wp), .chip_select_addr_bit(cs),
    .standby(standby), .busy(busy));
  ees_master_model #(.HALF(125)) m (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) if (busy === 1'b1) busy_len++;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  function automatic logic [7:0] slv(input logic [3:0] dv, input logic c,
                                     input logic [1:0] hi, input logic rw);
    return {dv, c, hi, rw};
  endfunction : slv

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic summarize();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic wr_hdr(input logic [7:0] sb, input logic [15:0] ad);
    m.bus_start();
    m.send_byte(sb, ack);
    check(ack, 1'b1);
    m.send_byte(ad[15:8], ack);
    check(ack, 1'b1);
    m.send_byte(ad[7:0], ack);
    check(ack, 1'b1);
  endtask : wr_hdr

  task automatic rd_chk(input logic [17:0] ad, input logic [7:0] e0, input logic [7:0] e1,
                        input int n);
    logic [7:0] q;
    wr_hdr(slv(ees_pkg::DEV_MAIN, cs, ad[17:16], 1'b0), ad[15:0]);
    m.bus_start();
    m.send_byte(slv(ees_pkg::DEV_MAIN, cs, ad[17:16], 1'b1), ack);
    check(ack, 1'b1);
    m.recv_byte(n == 1, q);
    check(q, e0);
    if (n > 1) begin
      m.recv_byte(1'b1, q);
      check(q, e1);
    end
    m.bus_stop();
  endtask : rd_chk

  task automatic wait_idle();
    for (int i = 0; i < WR + 200 && busy !== 1'b0; i++) @(negedge clk);
    check(busy, 1'b0);
  endtask : wait_idle

  initial begin
    rst      = 1'b1;
    wp       = 1'b0;
    cs       = 1'b1;
    n_errors = 0;
    checked  = 0;
    busy_len = 0;
    rnd      = 32'h0001_04db;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({standby, busy, sda_oe_n}, 3'b101);
    repeat (8) @(negedge clk);
    // Slave byte sent while reset is held
    rst = 1'b1;
    m.bus_start();
    m.send_byte(slv(ees_pkg::DEV_MAIN, cs, 2'b00, 1'b0), ack);
    check(ack, 1'b0);
    m.bus_stop();
    rst = 1'b0;
    repeat (8) @(negedge clk);
    // Partial page write that rolls over inside the page
    rnd = lfsr_next(rnd);
    a = {rnd[17:8], 8'hfe};
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr_next(rnd);
      d[i] = rnd[7:0];
    end
    wr_hdr(slv(ees_pkg::DEV_MAIN, cs, a[17:16], 1'b0), a[15:0]);
    for (int i = 0; i < 3; i++) begin
      m.send_byte(d[i], ack);
      check(ack, 1'b1);
    end
    busy_len = 0;
    m.bus_stop();
    wait_idle();
    check(busy_len >= WR - 2 && busy_len <= WR + 2, 1'b1);
    check(standby, 1'b1);
    busy_len = 0;
    rd_chk(a, d[0], d[1], 2);
    repeat (10) @(negedge clk);
    check({busy_len[7:0], standby}, 9'h001);
    // Slave byte with the wrong chip-select bit
    m.bus_start();
    m.send_byte(slv(ees_pkg::DEV_MAIN, ~cs, a[17:16], 1'b0), ack);
    check(ack, 1'b0);
    m.bus_stop();
    // Protected write leaves the rolled-over byte untouched
    wp = 1'b1;
    busy_len = 0;
    wr_hdr(slv(ees_pkg::DEV_MAIN, cs, a[17:16], 1'b0), {a[15:8], 8'h00});
    m.send_byte(~d[2], ack);
    check(ack, 1'b0);
    m.bus_stop();
    repeat (10) @(negedge clk);
    check(busy_len, 0);
    wp = 1'b0;
    rd_chk({a[17:8], 8'h00}, d[2], 8'h00, 1);
    // Lock the identification page, probing the bus during the cycle
    wr_hdr(slv(ees_pkg::DEV_ID, cs, 2'b00, 1'b0), {ees_pkg::LOCK_ADDR_H, rnd[15:8]});
    m.send_byte(rnd[7:0], ack);
    check(ack, 1'b1);
    m.bus_stop();
    check(busy, 1'b1);
    m.bus_start();
    m.send_byte(slv(ees_pkg::DEV_MAIN, cs, 2'b00, 1'b0), ack);
    check(ack, 1'b0);
    m.bus_stop();
    wait_idle();
    wr_hdr(slv(ees_pkg::DEV_ID, cs, 2'b00, 1'b0), 16'h0003);
    m.send_byte(rnd[15:8], ack);
    check(ack, 1'b0);
    m.bus_stop();
    // Reset while the device holds its acknowledge
    m.bus_start();
    m.send_byte(slv(ees_pkg::DEV_MAIN, cs, a[17:16], 1'b0), ack);
    for (int i = 7; i >= 0; i--) m.clk_bit(a[8 + i], ack);
    repeat (4) @(negedge clk);
    check(sda_oe_n, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check({sda_oe_n, standby, busy}, 3'b110);
    rst = 1'b0;
    m.bus_stop();
    summarize();
  end

  // About 34 bytes of 2286 clocks, two write cycles, and some margin
  initial begin
    repeat (96000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule : i2c_eeprom_slave_overview_bench
